// ===== include/cmad_pkg.sv
// Constants and types for the signaling multiframe alignment detector.
// Assumes one receive E1 clock domain and a framer that marks timeslot 16.
package cmad_pkg;

  // ----------------------------------------------------------------
  // Select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_OFF_LO     = 2'h0;
  localparam logic [1:0] SEL_SIXTEEN    = 2'h1;
  localparam logic [1:0] SEL_TWO        = 2'h2;
  localparam logic [1:0] SEL_OFF_HI     = 2'h3;

  // ----------------------------------------------------------------
  // Pattern, counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MF_PATTERN     = 4'h0;
  localparam logic [3:0] SIXTEEN_MISSES = 4'hf;
  localparam logic [3:0] TWO_MISSES     = 4'h1;
  localparam logic [3:0] MISS_MAX       = 4'hf;
  localparam logic [3:0] MISS_RESET     = 4'h0;
  localparam logic       LOSS_RESET     = 1'b1;

  // All state of the detector
  typedef struct packed {
    logic [3:0] miss_cnt;
    logic       declare;
    logic       loss;
  } cmad_state_type;

endpackage : cmad_pkg

// ===== src/cmad_detect.sv
// Receive-side detector of the signaling multiframe in timeslot 16.
// Assumes timeslot 16 strobe, nibble and select come from logic on I_CLK.
`timescale 1ns/1ps
`default_nettype none

module cmad_detect
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RSTN,
  // Configuration
  input  wire logic [1:0] I_SIG_MULTIFRAME_ALIGN_SELECT,
  // Timeslot 16 from the framer
  input  wire logic       I_TS16_VALID,
  input  wire logic [3:0] I_TS16_NIBBLE,
  // Loss criteria met elsewhere
  input  wire logic       I_LOSS_SET,
  // Status
  output logic            O_MF_ALIGN_DECLARE,
  output logic            O_LOSS_SIG_MF,
  output logic [3:0]      O_MISS_COUNT
);
  import cmad_pkg::*;

  cmad_state_type st_r;
  cmad_state_type st_nxt;
  logic           enabled;
  logic           hit;
  logic [3:0]     need;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.declare = 1'b0;
    enabled = (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_SIXTEEN) ||
              (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_TWO);
    need    = (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_SIXTEEN) ? SIXTEEN_MISSES : TWO_MISSES;
    hit     = (I_TS16_NIBBLE == MF_PATTERN);
    if (!enabled) begin
      st_nxt.miss_cnt = MISS_RESET;
    end else if (I_TS16_VALID) begin
      if (hit) begin
        st_nxt.declare  = (st_r.miss_cnt >= need);
        st_nxt.miss_cnt = MISS_RESET;
      end else if (st_r.miss_cnt != MISS_MAX) begin
        st_nxt.miss_cnt = st_r.miss_cnt + 4'h1;
      end
    end
    if (I_LOSS_SET) begin
      st_nxt.loss = 1'b1;
    end else if (st_nxt.declare) begin
      st_nxt.loss = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r.miss_cnt <= MISS_RESET;
      st_r.declare  <= 1'b0;
      st_r.loss     <= LOSS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_MF_ALIGN_DECLARE = st_r.declare;
  assign O_LOSS_SIG_MF      = st_r.loss;
  assign O_MISS_COUNT       = st_r.miss_cnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper terms for the checks
  logic chk_sel_off;
  logic chk_sel_two;
  logic chk_sel_sixteen;
  logic chk_hit;
  logic chk_miss;

  assign chk_sel_off     = (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_OFF_LO) ||
                           (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_OFF_HI);
  assign chk_sel_two     = (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_TWO);
  assign chk_sel_sixteen = (I_SIG_MULTIFRAME_ALIGN_SELECT == SEL_SIXTEEN);
  assign chk_hit         = I_TS16_VALID && (I_TS16_NIBBLE == MF_PATTERN);
  assign chk_miss        = I_TS16_VALID && (I_TS16_NIBBLE != MF_PATTERN);

  // Steps of the two-frame algorithm
  sequence s_two_miss;
    chk_sel_two && chk_miss;
  endsequence

  sequence s_two_gap;
    chk_sel_two && !I_TS16_VALID;
  endsequence

  sequence s_two_hit;
    chk_sel_two && chk_hit;
  endsequence

  property p_off_silent;
    @(posedge I_CLK) disable iff (!I_RSTN)
      chk_sel_off |=> !O_MF_ALIGN_DECLARE && (O_MISS_COUNT == MISS_RESET);
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("Declare while disabled");

  property p_miss_counts;
    @(posedge I_CLK) disable iff (!I_RSTN)
      chk_sel_sixteen && chk_miss && (O_MISS_COUNT != MISS_MAX)
      |=> (O_MISS_COUNT == $past(O_MISS_COUNT) + 4'h1);
  endproperty
  a_miss_counts: assert property (p_miss_counts) else $error("Miss frame not counted");

  property p_sixteen_decl;
    @(posedge I_CLK) disable iff (!I_RSTN)
      chk_sel_sixteen && chk_hit
      |=> (O_MF_ALIGN_DECLARE == ($past(O_MISS_COUNT) == SIXTEEN_MISSES));
  endproperty
  a_sixteen_decl: assert property (p_sixteen_decl) else $error("Sixteen-frame decision wrong");

  property p_two_decl;
    @(posedge I_CLK) disable iff (!I_RSTN)
      s_two_miss ##1 s_two_gap ##1 s_two_hit |=> O_MF_ALIGN_DECLARE;
  endproperty
  a_two_decl: assert property (p_two_decl) else $error("Two-frame alignment missed");

  property p_two_no_repeat;
    @(posedge I_CLK) disable iff (!I_RSTN)
      chk_sel_two && chk_hit && (O_MISS_COUNT == MISS_RESET)
      |=> !O_MF_ALIGN_DECLARE;
  endproperty
  a_two_no_repeat: assert property (p_two_no_repeat) else $error("Declare without a miss");

  property p_loss_clear;
    @(posedge I_CLK) disable iff (!I_RSTN)
      O_MF_ALIGN_DECLARE && !$past(I_LOSS_SET) |-> !O_LOSS_SIG_MF;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("Defect not cleared");

  property p_loss_set;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_LOSS_SET |=> O_LOSS_SIG_MF;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("Defect set lost");

  property p_declare_pulse;
    @(posedge I_CLK) disable iff (!I_RSTN)
      O_MF_ALIGN_DECLARE |=> !O_MF_ALIGN_DECLARE;
  endproperty
  a_declare_pulse: assert property (p_declare_pulse) else $error("Declare longer than a cycle");

  property p_two_back_to_back;
    @(posedge I_CLK) disable iff (!I_RSTN)
      s_two_miss ##1 s_two_hit |=> O_MF_ALIGN_DECLARE;
  endproperty
  a_two_back_to_back: assert property (p_two_back_to_back) else $error("Adjacent frames missed");

  property p_two_miss_counts;
    @(posedge I_CLK) disable iff (!I_RSTN)
      chk_sel_two && chk_miss && (O_MISS_COUNT != MISS_MAX)
      |=> (O_MISS_COUNT == $past(O_MISS_COUNT) + 4'h1);
  endproperty
  a_two_miss_counts: assert property (p_two_miss_counts) else $error("Two-frame miss not counted");

  property p_hit_clears;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !chk_sel_off && chk_hit |=> (O_MISS_COUNT == MISS_RESET);
  endproperty
  a_hit_clears: assert property (p_hit_clears) else $error("Pattern frame kept the count");

  property p_idle_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !chk_sel_off && !I_TS16_VALID |=> (O_MISS_COUNT == $past(O_MISS_COUNT));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Count moved without a frame");

  property p_miss_saturates;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !chk_sel_off && chk_miss && (O_MISS_COUNT == MISS_MAX) |=> (O_MISS_COUNT == MISS_MAX);
  endproperty
  a_miss_saturates: assert property (p_miss_saturates) else $error("Miss count wrapped");

  property p_declare_cause;
    @(posedge I_CLK) disable iff (!I_RSTN)
      O_MF_ALIGN_DECLARE |-> $past(chk_hit) && !$past(chk_sel_off);
  endproperty
  a_declare_cause: assert property (p_declare_cause) else $error("Declare without a pattern frame");

  property p_loss_stays_clear;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !O_LOSS_SIG_MF && !I_LOSS_SET |=> !O_LOSS_SIG_MF;
  endproperty
  a_loss_stays_clear: assert property (p_loss_stays_clear) else $error("Defect set on its own");

  property p_loss_falls_on_declare;
    @(posedge I_CLK) disable iff (!I_RSTN)
      O_LOSS_SIG_MF ##1 !O_LOSS_SIG_MF |-> O_MF_ALIGN_DECLARE;
  endproperty
  a_loss_falls_on_declare: assert property (p_loss_falls_on_declare) else $error("Defect cleared without declare");

endmodule : cmad_detect

`default_nettype wire

// ===== sim/cmad_e1_src.sv
// Remote E1 end: presents timeslot 16 bits 1-4 once per frame.
// Assumes the bench asks for each frame through send_frame, or for two adjacent frames through send_pair.
`timescale 1ns/1ps
`default_nettype none
module cmad_e1_src (
  // Receive clock
  input  wire logic       i_clk,
  // Timeslot 16 stream
  output var  logic       o_valid,
  output var  logic [3:0] o_nibble
);
  initial begin
    o_valid  = 1'b0;
    o_nibble = 4'h5;
  end
  task automatic send_frame(input logic [3:0] nib);
    @(posedge i_clk);
    o_valid  <= 1'b1;
    o_nibble <= nib;
    @(posedge i_clk);
    o_valid  <= 1'b0;
    o_nibble <= ~nib;
    #1;
  endtask : send_frame
  task automatic send_pair(input logic [3:0] nib_a, input logic [3:0] nib_b);
    @(posedge i_clk);
    o_valid  <= 1'b1;
    o_nibble <= nib_a;
    @(posedge i_clk);
    o_nibble <= nib_b;
    @(posedge i_clk);
    o_valid  <= 1'b0;
    o_nibble <= ~nib_b;
    #1;
  endtask : send_pair
endmodule : cmad_e1_src
`default_nettype wire

// ===== sim/tb.sv
// Bench for the signaling multiframe detector.
// Assumes one clock; frames come from the far-end model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmad_pkg::*;
  logic       clk, rstn, lset, vld, decl, loss;
  logic [1:0] sel;
  logic [3:0] nib, miss;
  int         n_fail = 0;
  int         total_checks = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cmad_e1_src u_src (.i_clk(clk), .o_valid(vld), .o_nibble(nib));
  cmad_detect u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_SIG_MULTIFRAME_ALIGN_SELECT(sel),
    .I_TS16_VALID(vld), .I_TS16_NIBBLE(nib), .I_LOSS_SET(lset),
    .O_MF_ALIGN_DECLARE(decl), .O_LOSS_SIG_MF(loss), .O_MISS_COUNT(miss));
  task automatic chk(input logic d, input logic l, input logic [3:0] m);
    total_checks++;
    if ({decl, loss, miss} !== {d, l, m}) begin
      n_fail++;
      $display("ERROR t=%0t got %b%b%h exp %b%b%h", $time, decl, loss, miss, d, l, m);
    end
  endtask : chk
  task automatic misses(input int n);
    repeat (n) u_src.send_frame(4'h9);
  endtask : misses
  task automatic t_off;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) sel <= (i == 0) ? SEL_OFF_LO : SEL_OFF_HI;
      misses(3);
      chk(1'b0, 1'b1, 4'h0);
      u_src.send_frame(MF_PATTERN);
      chk(1'b0, 1'b1, 4'h0);
    end
    $display("test off done");
  endtask : t_off
  task automatic t_two;
    @(posedge clk) sel <= SEL_TWO;
    misses(1);
    chk(1'b0, 1'b1, 4'h1);
    u_src.send_frame(MF_PATTERN);
    chk(1'b1, 1'b0, 4'h0);
    @(posedge clk) #1;
    chk(1'b0, 1'b0, 4'h0);
    u_src.send_frame(MF_PATTERN);
    chk(1'b0, 1'b0, 4'h0);
    @(posedge clk) lset <= 1'b1;
    @(posedge clk) lset <= 1'b0;
    #1 chk(1'b0, 1'b1, 4'h0);
    u_src.send_pair(4'h9, MF_PATTERN);
    chk(1'b1, 1'b0, 4'h0);
    $display("test two-frame done");
  endtask : t_two
  task automatic t_sixteen;
    @(posedge clk) lset <= 1'b1;
    @(posedge clk) lset <= 1'b0;
    sel <= SEL_SIXTEEN;
    #1 chk(1'b0, 1'b1, 4'h0);
    misses(14);
    chk(1'b0, 1'b1, 4'he);
    u_src.send_frame(MF_PATTERN);
    chk(1'b0, 1'b1, 4'h0);
    misses(15);
    chk(1'b0, 1'b1, 4'hf);
    u_src.send_frame(MF_PATTERN);
    chk(1'b1, 1'b0, 4'h0);
    misses(16);
    chk(1'b0, 1'b0, 4'hf);
    u_src.send_frame(MF_PATTERN);
    chk(1'b1, 1'b0, 4'h0);
    misses(3);
    chk(1'b0, 1'b0, 4'h3);
    @(posedge clk) sel <= SEL_TWO;
    u_src.send_frame(MF_PATTERN);
    chk(1'b1, 1'b0, 4'h0);
    $display("test sixteen-frame done");
  endtask : t_sixteen
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rstn = 1'b0;
    lset = 1'b0;
    sel  = SEL_OFF_LO;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1 chk(1'b0, 1'b1, 4'h0);
    t_off();
    t_two();
    t_sixteen();
    tally_and_finish();
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
